// ===== src/cfm_clock_switch.sv
// clock source switch with fail-safe external clock monitor
// Notes on behaviour
// - pll input follows request; runs old meanwhile
// - suspend during the clock gate of every switch not done on wake or fail, and any pll relock
// - sleep before completion abandons the switch
// - wake, hold clear: new clock, done flag
// - wake, hold set: old clock, re-request
// - monitor only when enabled, external modes
// - sample clock is low oscillator over 64
// - latch set ext fall, cleared sample rise
// - fail: sample half-cycle without ext fall
// - on fail use 1 MHz internal, flag
// - interrupt when fail flag and enable
// - stay internal until new request succeeds
// - fail-safe cleared by reset, sleep, completed switch
// - external switch restarts start-up timer
// - still failed after switch-back: flag again
// - detect after start-up timer; skipped in ec
// - request: bit7 zero, source 6-4, divider 3-0
// - reserved source code selects 1 MHz internal
// - switch disabled: request ignores writes
// - divider resets 0010 for strapped 1 MHz source code
// - current register mirrors request at reset
// - source code decode per table
// - divider power of two up to 512
// - hold clear: switch on ready, update, clear
// - hold set: postpone until hold cleared/abandoned
//
// The address map and register access over APB are this design's own decisions.
module cfm_clock_switch
   import cfm_pkg::*;
#(
   parameter int unsigned OST_EDGES = cfm_pkg::OST_EDGES_DEF
)
(
   // clock and reset
   input  wire logic              i_clock,
   input  wire logic              i_sys_rst,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [11:0]       i_paddr,
   input  wire logic [31:0]       i_pwdata,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // configuration straps
   input  wire logic              i_fail_monitor_en_cfg,
   input  wire logic              i_switch_enable_cfg,
   input  wire logic [2:0]        i_reset_source_cfg,
   input  wire logic              i_external_clock_mode,
   // oscillator side
   input  wire logic              i_ext_clk,
   input  wire logic              i_lf_osc_clk,
   input  wire logic [7:0]        i_osc_ready,
   input  wire logic              i_pll_lock,
   // power control
   input  wire logic              i_sleep_cmd,
   input  wire logic              i_wake,
   // system clock control
   output cfm_pkg::cfm_sel_s      o_sys_sel,
   output logic      [2:0]        o_osc_enable_src,
   output logic                   o_clk_run,
   output logic                   o_sys_suspend,
   output logic                   o_sleeping,
   output logic                   o_osc_fail_irq
);

   cfm_state_e    state_r, state_nxt;
   cfm_sel_s      req_r;
   cfm_sel_s      cur_r;
   logic          init_done_r;
   logic          hold_r, irq_en_r;
   logic          ready_r, done_r, fail_flag_r, fsafe_r;
   logic          sleep_r, fresh_r;
   logic [31:0]   prdata_r;
   logic          slverr_r;
   logic [3:0]    gate_cnt_r;
   logic          ext_d_r, lf_d_r, samp_r;
   logic [5:0]    lf_cnt_r;
   logic          det_latch_r;
   logic [15:0]   ost_cnt_r;
   logic          ost_done_r;

   // bus decode
   wire           setup_ph  = i_psel & ~i_penable;
   wire           wr_access = i_psel & i_penable & i_pwrite;
   wire           hit_req   = (i_paddr == OFS_REQUEST);
   wire           hit_cur   = (i_paddr == OFS_CURRENT);
   wire           hit_ctl   = (i_paddr == OFS_CTRL);
   wire           unmapped  = ~(hit_req | hit_cur | hit_ctl);
   // switch disabled keeps the power-on request
   wire           wr_req    = wr_access & hit_req & i_switch_enable_cfg;
   wire           wr_ctl    = wr_access & hit_ctl;

   // reserved source codes fall back to 1 MHz internal
   wire [2:0]     wr_src_raw = i_pwdata[SRC_MSB:SRC_LSB];
   wire [2:0]     wr_src     = (wr_src_raw == SRC_RSV_A ||
                                wr_src_raw == SRC_RSV_B) ?
                               SRC_HF_1M : wr_src_raw;
   // reserved divider codes clamp to 512
   wire [3:0]     wr_div_raw = i_pwdata[DIV_MSB:DIV_LSB];
   wire [3:0]     wr_div     = (wr_div_raw > DIV_512) ?
                               DIV_512 : wr_div_raw;

   // divider default follows the strapped source
   wire [3:0]     rst_div    = (i_reset_source_cfg == SRC_HF_1M) ?
                               DIV_4 : DIV_1;
   wire [2:0]     rst_src    = (i_reset_source_cfg == SRC_RSV_A ||
                                i_reset_source_cfg == SRC_RSV_B) ?
                               SRC_HF_1M : i_reset_source_cfg;

   // sources that need the external crystal or clock
   function automatic logic is_ext(input logic [2:0] s);
      is_ext = (s == SRC_EXT_OSC) || (s == SRC_EXT_PLL) ||
               (s == SRC_SEC_OSC);
   endfunction : is_ext

   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == SRC_HF_PLL) || (s == SRC_EXT_PLL);
   endfunction : is_pll

   wire           pending   = (req_r != cur_r);
   wire           start_ok  = pending & ~sleep_r & init_done_r &
                              (~fsafe_r | fresh_r);
   // external targets wait on the start-up timer
   wire           ost_ok    = ~is_ext(req_r.src) | ost_done_r |
                              i_external_clock_mode;
   wire           src_ready = i_osc_ready[req_r.src] & ost_ok;
   // pll input change needs a fresh lock
   wire           need_lock = is_pll(req_r.src) &
                              (req_r.src != cur_r.src);
   wire           gate_done = (gate_cnt_r == 4'(GATE_CYCLES));

   // monitor edges from the sampled oscillator levels
   wire           ext_fall  = ext_d_r & ~i_ext_clk;
   wire           lf_rise   = ~lf_d_r & i_lf_osc_clk;
   wire           lf_wrap   = (lf_cnt_r == 6'(LF_HALF_COUNT - 1));
   wire           samp_rise = lf_rise & lf_wrap & ~samp_r;
   wire           samp_fall = lf_rise & lf_wrap & samp_r;
   // monitor active only after start-up, on external source
   wire           mon_on    = i_fail_monitor_en_cfg & init_done_r &
                              is_ext(cur_r.src) & ~sleep_r & ~fsafe_r &
                              (ost_done_r | i_external_clock_mode);
   // no falling external edge for a whole sample half-cycle
   wire           fail_det  = mon_on & samp_fall & ~det_latch_r &
                              ~ext_fall;

   wire           sleep_go  = i_sleep_cmd & ~sleep_r;
   wire           wake_go   = i_wake & sleep_r;
   wire           do_switch = (state_r == ST_SWITCH);
   wire           rdy_event = (state_r == ST_WAIT) & src_ready &
                              ~ready_r;

   // sequencing of a switch
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:
         begin
            if (start_ok)
               state_nxt = ST_WAIT;
         end
         ST_WAIT:
         begin
            // hold keeps the old source running
            if (!pending)
               state_nxt = ST_IDLE;
            else if (src_ready && !hold_r)
               state_nxt = ST_GATE;
         end
         ST_GATE:
         begin
            if (gate_done)
               state_nxt = need_lock ? ST_LOCK : ST_SWITCH;
         end
         ST_LOCK:
         begin
            if (i_pll_lock)
               state_nxt = ST_SWITCH;
         end
         ST_SWITCH:
            state_nxt = ST_IDLE;
      endcase
      // sleep abandons any switch in progress
      if (sleep_go || sleep_r || fail_det)
         state_nxt = ST_IDLE;
   end

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // clock held low for a few cycles while the mux moves
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         gate_cnt_r <= 4'h0;
      else if (state_r == ST_GATE && !gate_done)
         gate_cnt_r <= gate_cnt_r + 4'h1;
      else if (state_r != ST_GATE)
         gate_cnt_r <= 4'h0;
   end

   // request and current, loaded from straps after release
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         init_done_r <= 1'b0;
         req_r       <= '0;
         cur_r       <= '0;
      end
      else if (!init_done_r)
      begin
         init_done_r <= 1'b1;
         req_r       <= '{src: rst_src, div: rst_div};
         cur_r       <= '{src: rst_src, div: rst_div};
      end
      else
      begin
         if (wr_req)
            req_r <= '{src: wr_src, div: wr_div};
         // fail forces the 1 MHz internal source
         if (fail_det)
            cur_r <= '{src: SRC_HF_1M, div: DIV_1};
         // switch or wake completes the change
         else if (do_switch || (wake_go && !hold_r && !fsafe_r))
            cur_r <= req_r;
      end
   end

   // control bits written by software
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         hold_r   <= HOLD_RST;
         irq_en_r <= IRQEN_RST;
      end
      else if (wr_ctl)
      begin
         hold_r   <= i_pwdata[CTL_HOLD_BIT];
         irq_en_r <= i_pwdata[CTL_IRQEN_BIT];
      end
   end

   // status flags; a hardware set beats a software clear
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ready_r     <= 1'b0;
         done_r      <= 1'b0;
         fail_flag_r <= 1'b0;
      end
      else
      begin
         // ready clears once the switch lands
         if (rdy_event)
            ready_r <= 1'b1;
         else if (state_nxt == ST_IDLE)
            ready_r <= 1'b0;
         // wake with hold clear reports the switch
         if (rdy_event || (wake_go && !hold_r && pending))
            done_r <= 1'b1;
         else if (wr_ctl && i_pwdata[CTL_DONE_BIT])
            done_r <= 1'b0;
         // fail sets the flag, every time it is seen
         if (fail_det)
            fail_flag_r <= 1'b1;
         else if (wr_ctl && i_pwdata[CTL_FAIL_BIT])
            fail_flag_r <= 1'b0;
      end
   end

   // fail-safe condition and fresh-request tracking
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         fsafe_r <= 1'b0;
         fresh_r <= 1'b0;
      end
      else
      begin
         // held until sleep or a successful new switch
         if (fail_det)
            fsafe_r <= 1'b1;
         else if (sleep_go || do_switch)
            fsafe_r <= 1'b0;
         if (fail_det || do_switch)
            fresh_r <= 1'b0;
         else if (wr_req)
            fresh_r <= 1'b1;
      end
   end

   // sleep state
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         sleep_r <= 1'b0;
      else if (sleep_go)
         sleep_r <= 1'b1;
      else if (wake_go)
         sleep_r <= 1'b0;
   end

   // low oscillator divided by 64 into the sample clock
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ext_d_r  <= 1'b0;
         lf_d_r   <= 1'b0;
         lf_cnt_r <= 6'h00;
         samp_r   <= 1'b0;
      end
      else
      begin
         ext_d_r <= i_ext_clk;
         lf_d_r  <= i_lf_osc_clk;
         if (lf_rise)
            lf_cnt_r <= lf_wrap ? 6'h00 : lf_cnt_r + 6'h01;
         if (lf_rise && lf_wrap)
            samp_r <= ~samp_r;
      end
   end

   // detector latch; an external fall wins a tie
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
         det_latch_r <= 1'b0;
      else if (ext_fall)
         det_latch_r <= 1'b1;
      else if (samp_rise)
         det_latch_r <= 1'b0;
   end

   // start-up timer counts external falls; restarts on reset
   // wake and each new external target
   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         ost_cnt_r  <= 16'h0000;
         ost_done_r <= 1'b0;
      end
      else if (wake_go || (state_r == ST_IDLE && start_ok &&
                           is_ext(req_r.src) && req_r.src != cur_r.src))
      begin
         ost_cnt_r  <= 16'h0000;
         ost_done_r <= 1'b0;
      end
      else if (ext_fall && !ost_done_r && !sleep_r)
      begin
         ost_cnt_r  <= ost_cnt_r + 16'h0001;
         if (ost_cnt_r == 16'(OST_EDGES - 1))
            ost_done_r <= 1'b1;
      end
   end

   // read data captured in the setup phase, so access has no wait
   wire [31:0] ctl_word = {25'h0000000,
                           sleep_r, fsafe_r, irq_en_r,
                           fail_flag_r, done_r, ready_r, hold_r};
   wire [31:0] rd_mux   = hit_req ? {25'h0000000, req_r} :
                          hit_cur ? {25'h0000000, cur_r} :
                          hit_ctl ? ctl_word : 32'h00000000;

   always_ff @(posedge i_clock or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         prdata_r <= 32'h00000000;
         slverr_r <= 1'b0;
      end
      else if (setup_ph)
      begin
         prdata_r <= rd_mux;
         slverr_r <= unmapped;
      end
   end

   assign o_prdata         = prdata_r;
   assign o_pready         = 1'b1;
   assign o_pslverr        = i_psel & i_penable & slverr_r;
   assign o_sys_sel        = cur_r;
   assign o_osc_enable_src = req_r.src;
   assign o_clk_run        = (state_r != ST_GATE) & ~sleep_r;
   // system held through the clock gate of every switch not done on wake or fail, and any pll relock
   assign o_sys_suspend    = (state_r == ST_GATE) |
                             (state_r == ST_LOCK);
   assign o_sleeping       = sleep_r;
   assign o_osc_fail_irq   = fail_flag_r & irq_en_r;

endmodule : cfm_clock_switch

// ===== shared/cfm_pkg.sv
// constants and types for the clock switch and fail-safe monitor
package cfm_pkg;

   // source codes
   localparam logic [2:0] SRC_HF_PLL   = 3'h0;
   localparam logic [2:0] SRC_EXT_PLL  = 3'h1;
   localparam logic [2:0] SRC_RSV_A    = 3'h2;
   localparam logic [2:0] SRC_SEC_OSC  = 3'h3;
   localparam logic [2:0] SRC_LF_OSC   = 3'h4;
   localparam logic [2:0] SRC_RSV_B    = 3'h5;
   localparam logic [2:0] SRC_HF_1M    = 3'h6;
   localparam logic [2:0] SRC_EXT_OSC  = 3'h7;

   // divider codes
   localparam logic [3:0] DIV_1        = 4'h0;
   localparam logic [3:0] DIV_4        = 4'h2;
   localparam logic [3:0] DIV_512      = 4'h9;

   // register field layout
   localparam int SRC_LSB = 4;
   localparam int SRC_MSB = 6;
   localparam int DIV_LSB = 0;
   localparam int DIV_MSB = 3;

   // apb byte offsets
   localparam logic [11:0] OFS_REQUEST = 12'h000;
   localparam logic [11:0] OFS_CURRENT = 12'h004;
   localparam logic [11:0] OFS_CTRL    = 12'h008;

   // control / status register bit positions
   localparam int CTL_HOLD_BIT  = 0;
   localparam int CTL_READY_BIT = 1;
   localparam int CTL_DONE_BIT  = 2;
   localparam int CTL_FAIL_BIT  = 3;
   localparam int CTL_IRQEN_BIT = 4;
   localparam int CTL_FSAFE_BIT = 5;
   localparam int CTL_SLEEP_BIT = 6;

   // reset values
   localparam logic       HOLD_RST  = 1'b0;
   localparam logic       IRQEN_RST = 1'b0;

   // monitor sample clock: low-frequency oscillator divided by 64
   localparam int unsigned LF_DIV_FACTOR = 64;
   localparam int unsigned LF_HALF_COUNT = LF_DIV_FACTOR / 2;

   // clock gate hold-off around the mux change, in system clock ns
   localparam int unsigned CLK_PERIOD_NS  = 8;
   localparam int unsigned GATE_TIME_NS   = 24;
   localparam int unsigned GATE_CYCLES    =
      (GATE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // start-up timer default, in external clock falling edges
   localparam int unsigned OST_EDGES_DEF  = 1024;

   typedef struct packed {
      logic [2:0] src;
      logic [3:0] div;
   } cfm_sel_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_WAIT,
      ST_GATE,
      ST_LOCK,
      ST_SWITCH
   } cfm_state_e;

endpackage : cfm_pkg

// ===== dv/cfm_clock_switch_asserts.sv
// port-level assertions for the clock switch block
module cfm_clock_switch_asserts
   import cfm_pkg::*;
#(
   parameter int unsigned OST_EDGES = 4
)
(
   // watched ports
   input wire logic               i_clock,
   input wire logic               i_sys_rst,
   input wire logic               i_psel,
   input wire logic               i_penable,
   input wire logic               i_pwrite,
   input wire logic [11:0]        i_paddr,
   input wire logic [31:0]        i_pwdata,
   input wire logic [31:0]        o_prdata,
   input wire logic               o_pslverr,
   input wire logic               i_switch_enable_cfg,
   input wire cfm_pkg::cfm_sel_s  o_sys_sel,
   input wire logic [2:0]         o_osc_enable_src,
   input wire logic               o_clk_run,
   input wire logic               o_sys_suspend,
   input wire logic               o_sleeping,
   input wire logic               o_osc_fail_irq
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   wire acc    = i_psel && i_penable;
   wire wr_req = acc && i_pwrite && i_paddr == OFS_REQUEST;
   wire wr_ctl = acc && i_pwrite && i_paddr == OFS_CTRL;
   wire rsv    = i_pwdata[6:4] == SRC_RSV_A || i_pwdata[6:4] == SRC_RSV_B;
   wire mapped = i_paddr == OFS_REQUEST || i_paddr == OFS_CURRENT ||
                 i_paddr == OFS_CTRL;

   a_unmapped_err:
      assert property (acc && !mapped |-> o_pslverr)
      else $error("unmapped access gave no slave error");
   a_read_upper:
      assert property (acc && !i_pwrite |-> o_prdata[31:7] == 25'h0)
      else $error("read data above bit 6 not zero");
   a_req_enable:
      assert property (wr_req && i_switch_enable_cfg && !rsv
                       |=> o_osc_enable_src == $past(i_pwdata[6:4]))
      else $error("requested source not enabled");
   a_req_locked:
      assert property (wr_req && !i_switch_enable_cfg
                       |=> $stable(o_osc_enable_src))
      else $error("protected request register changed");
   a_suspend_gate:
      assert property ($rose(o_sys_suspend) |-> !o_clk_run)
      else $error("suspend without clock gated");
   a_gate_width:
      assert property ($fell(o_clk_run) |-> (!o_clk_run) [*4])
      else $error("clock gate shorter than four cycles");
   a_sel_legal:
      assert property (o_sys_sel.src != SRC_RSV_A &&
                       o_sys_sel.src != SRC_RSV_B && o_sys_sel.div <= DIV_512)
      else $error("reserved source or divider in use");
   a_sleep_hold:
      assert property (o_sleeping && $past(o_sleeping)
                       |-> $stable(o_sys_sel) && !o_sys_suspend)
      else $error("clock switched while asleep");
   a_irq_mask:
      assert property (wr_ctl && !i_pwdata[CTL_IRQEN_BIT] |=> !o_osc_fail_irq)
      else $error("interrupt stays up after masking");

   c_suspend: cover property ($rose(o_sys_suspend));
   c_sleep:   cover property ($rose(o_sleeping));
   c_irq:     cover property ($rose(o_osc_fail_irq));
endmodule : cfm_clock_switch_asserts

bind cfm_clock_switch cfm_clock_switch_asserts #(.OST_EDGES(OST_EDGES)) u_chk (
   .i_clock, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
   .o_prdata, .o_pslverr, .i_switch_enable_cfg, .o_sys_sel, .o_osc_enable_src,
   .o_clk_run, .o_sys_suspend, .o_sleeping, .o_osc_fail_irq
);

// ===== dv/cfm_osc_model.sv
// oscillator side model: external clock, low oscillator, ready, pll lock
module cfm_osc_model
#(
   parameter int unsigned EXT_HALF = 4,
   parameter int unsigned LF_HALF  = 2,
   parameter int unsigned LOCK_DLY = 6
)
(
   // system clock and bench controls
   input  wire logic       i_clock,
   input  wire logic       i_ext_run,
   input  wire logic [7:0] i_rdy_mask,
   input  wire logic       i_sys_suspend,
   // oscillator outputs
   output logic            o_ext_clk,
   output logic            o_lf_clk,
   output logic [7:0]      o_osc_ready,
   output logic            o_pll_lock
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt_r      = 0;
   int unsigned lock_cnt_r = 0;
   logic        susp_r     = 1'b0;

   assign o_osc_ready = i_rdy_mask;
   assign o_pll_lock  = lock_cnt_r == 0;

   initial
   begin
      o_ext_clk = 1'b1;
      o_lf_clk  = 1'b0;
   end

   always @(posedge i_clock)
   begin
      cnt_r  <= cnt_r + 1;
      susp_r <= i_sys_suspend;
      if (cnt_r % LF_HALF == LF_HALF - 1)
         o_lf_clk <= !o_lf_clk;
      // a stopped oscillator parks high, so no falling edge reaches the latch
      if (!i_ext_run)
         o_ext_clk <= 1'b1;
      else if (cnt_r % EXT_HALF == EXT_HALF - 1)
         o_ext_clk <= !o_ext_clk;
      // lock is lost while the input changes over, regained slowly
      if (i_sys_suspend && !susp_r)
         lock_cnt_r <= LOCK_DLY;
      else if (lock_cnt_r != 0)
         lock_cnt_r <= lock_cnt_r - 1;
   end
endmodule : cfm_osc_model

// ===== dv/tb.sv
// self-checking bench for the clock switch block
module tb;
   import cfm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clock;
   logic        i_sys_rst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sw_en = 1'b1;
   logic        sleep_cmd = 1'b0, wake = 1'b0, ext_run = 1'b1;
   logic        fmen = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  rdy_mask = 8'hFF, osc_ready;
   logic        pready, pslverr, err, ext_clk, lf_clk, pll_lock;
   logic        clk_run, suspend, sleeping, irq;
   logic [2:0]  en_src;
   cfm_sel_s    sys_sel;
   int          num_errors = 0, check_count = 0, cycles = 0;

   cfm_clock_switch #(.OST_EDGES(4)) dut (
      .i_clock, .i_sys_rst, .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_fail_monitor_en_cfg(fmen), .i_switch_enable_cfg(sw_en),
      .i_reset_source_cfg(SRC_HF_1M), .i_external_clock_mode(1'b0),
      .i_ext_clk(ext_clk), .i_lf_osc_clk(lf_clk), .i_osc_ready(osc_ready),
      .i_pll_lock(pll_lock), .i_sleep_cmd(sleep_cmd), .i_wake(wake),
      .o_sys_sel(sys_sel), .o_osc_enable_src(en_src), .o_clk_run(clk_run),
      .o_sys_suspend(suspend), .o_sleeping(sleeping), .o_osc_fail_irq(irq)
   );
   cfm_osc_model u_osc (
      .i_clock, .i_ext_run(ext_run), .i_rdy_mask(rdy_mask),
      .i_sys_suspend(suspend), .o_ext_clk(ext_clk), .o_lf_clk(lf_clk),
      .o_osc_ready(osc_ready), .o_pll_lock(pll_lock)
   );

   initial
   begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   always @(posedge i_clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [31:0] exp_cur(input logic [2:0] s,
                                           input logic [3:0] d);
      logic [2:0] es;
      es = (s == SRC_RSV_A || s == SRC_RSV_B) ? SRC_HF_1M : s;
      return {25'h0, es, (d > DIV_512) ? DIV_512 : d};
   endfunction : exp_cur

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge i_clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      // the answer is taken at the edge that samples pready high
      do
         @(posedge i_clock);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string nm, input logic [11:0] a,
                        input logic [31:0] e, input logic [31:0] m = '1);
      apb(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask : rdchk

   task automatic wait_sel(input logic [31:0] e, input int lim);
      int n;
      n = 0;
      @(negedge i_clock);
      while (sys_sel !== e[6:0] && n < lim)
      begin
         @(negedge i_clock);
         n++;
      end
      chk("sys_sel", {25'h0, sys_sel}, e);
   endtask : wait_sel

   task automatic pulse(input logic up);
      @(posedge i_clock);
      wake      <= up;
      sleep_cmd <= !up;
      @(posedge i_clock);
      wake      <= 1'b0;
      sleep_cmd <= 1'b0;
      repeat (20) @(posedge i_clock);
   endtask : pulse

   initial
   begin
      logic [31:0] w;
      w = $urandom(32'hF388);
      repeat (12) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_clock);
      rdchk("request", OFS_REQUEST, 32'h62);
      rdchk("current", OFS_CURRENT, 32'h62);
      rdchk("ctrl", OFS_CTRL, 32'h0);
      rdchk("unmapped", 12'h00C, 32'h0);
      chk("slverr", {31'h0, err}, 32'h1);
      sw_en <= 1'b0;
      apb(1'b1, OFS_REQUEST, 32'h40);
      rdchk("request", OFS_REQUEST, 32'h62);
      sw_en <= 1'b1;
      apb(1'b1, OFS_REQUEST, 32'hC3);
      rdchk("request", OFS_REQUEST, 32'h43);
      wait_sel(32'h43, 600);
      // every source code once, reserved ones too, then random picks
      for (int i = 0; i < 10; i++)
      begin
         w = $urandom;
         w[6:4] = (i < 8) ? 3'(i) : w[6:4];
         apb(1'b1, OFS_REQUEST, w);
         wait_sel(exp_cur(w[6:4], w[3:0]), 600);
         rdchk("current", OFS_CURRENT, exp_cur(w[6:4], w[3:0]));
      end
      apb(1'b1, OFS_REQUEST, 32'h40);
      wait_sel(32'h40, 600);
      apb(1'b1, OFS_CTRL, 32'h05);
      apb(1'b1, OFS_REQUEST, 32'h61);
      repeat (40) @(posedge i_clock);
      wait_sel(32'h40, 0);
      rdchk("ctrl", OFS_CTRL, 32'h07);
      pulse(1'b0);
      @(negedge i_clock);
      chk("sleeping", {31'h0, sleeping}, 32'h1);
      wait_sel(32'h40, 0);
      pulse(1'b1);
      wait_sel(32'h40, 0);
      apb(1'b1, OFS_CTRL, 32'h00);
      wait_sel(32'h61, 100);
      rdy_mask <= 8'hEF;
      apb(1'b1, OFS_CTRL, 32'h04);
      apb(1'b1, OFS_REQUEST, 32'h40);
      pulse(1'b0);
      rdy_mask <= 8'hFF;
      pulse(1'b1);
      wait_sel(32'h40, 0);
      rdchk("ctrl", OFS_CTRL, 32'h04, 32'h04);
      apb(1'b1, OFS_REQUEST, 32'h70);
      wait_sel(32'h70, 600);
      apb(1'b1, OFS_CTRL, 32'h14);
      // monitor disabled: a stopped clock must not trip the fallback
      fmen    <= 1'b0;
      ext_run <= 1'b0;
      repeat (400) @(posedge i_clock);
      wait_sel(32'h70, 0);
      @(posedge i_clock);
      fmen    <= 1'b1;
      wait_sel(32'h60, 1000);
      rdchk("ctrl", OFS_CTRL, 32'h38);
      @(negedge i_clock);
      chk("irq", {31'h0, irq}, 32'h1);
      // flag cleared and interrupt masked before any switch back
      apb(1'b1, OFS_CTRL, 32'h08);
      @(negedge i_clock);
      chk("irq", {31'h0, irq}, 32'h0);
      rdchk("ctrl", OFS_CTRL, 32'h20, 32'h38);
      apb(1'b1, OFS_REQUEST, 32'h70);
      repeat (300) @(posedge i_clock);
      wait_sel(32'h60, 0);
      rdchk("ctrl", OFS_CTRL, 32'h20, 32'h20);
      ext_run <= 1'b1;
      wait_sel(32'h70, 600);
      rdchk("ctrl", OFS_CTRL, 32'h04, 32'h24);
      // a second failure after the switch back raises the flag again
      ext_run <= 1'b0;
      wait_sel(32'h60, 1000);
      rdchk("ctrl", OFS_CTRL, 32'h08, 32'h08);
      end_sim();
   end
endmodule : tb
